// ===== hw/vil_pkg.sv
// Purpose: constants for the vectored interrupt logic
// Assumes: 8-bit register port, 25 MHz core clock
// Notes: register offsets are word indices on the plain port
package vil_pkg;
  // ***************************************************
  // register offsets
  // ***************************************************
  localparam logic [2:0] OFS_CTRL = 3'h0; // core interrupt control
  localparam logic [2:0] OFS_PFLAG = 3'h1; // peripheral flags
  localparam logic [2:0] OFS_PEN = 3'h2; // peripheral enables
  localparam logic [2:0] OFS_OPT = 3'h3; // option, edge select
  localparam logic [2:0] OFS_ISTAT = 3'h4; // sticky event status
  localparam logic [2:0] OFS_IMASK = 3'h5; // event mask
  localparam logic [2:0] OFS_STATE = 3'h6; // live block state
  // ***************************************************
  // control register bit positions, plus the option edge bit
  // ***************************************************
  localparam int B_GIE = 7; // global_irq_enable
  localparam int B_PERIPHERAL_GROUP_ENABLE = 6; // peripheral_group_enable
  localparam int B_TIE = 5; // timer_overflow_enable
  localparam int B_EIE = 4; // ext_pin_irq_enable
  localparam int B_PCE = 3; // port_change_enable
  localparam int B_TF = 2; // timer_overflow_flag
  localparam int B_EF = 1; // ext_pin_flag
  localparam int B_PF = 0; // port_change_flag
  localparam int B_EDGE = 6; // ext_edge_select in option
  // ***************************************************
  // reset values and misc
  // ***************************************************
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_OPT = 8'hFF;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [12:0] VEC_PC = 13'h0004; // interrupt vector
  localparam int ST_VEC = 0; // status bit: vector taken
  localparam int ST_WAKE = 1; // status bit: woke from sleep
  localparam logic [1:0] Q_LAST = 2'h3; // last quarter of a cycle
  localparam logic [1:0] WAIT_LAST = 2'h2; // boundaries before vector
endpackage : vil_pkg

// ===== hw/vil_top.sv
// Purpose: interrupt flags, enables, vectoring and sleep wake-up
// Assumes: sequencer supplies pc and return-from-irq pulse
// Notes: core pins are synchronised; timer/peripheral are same-clock
`timescale 1ns/100ps
// Operation
// R1 - up to seventeen sources, each own flag; code has eleven (3 core, 8 peripheral)
// R2 - flags set regardless of any enable
// R3 - global enable bit 7 gates everything
// R4 - enabled flag with global enable vectors
// R5 - reset clears the global enable
// R6 - vector clears enable, pushes, loads 0004h
// R7 - return-from-irq pops and sets enable
// R8 - peripheral flags gated by group enable
// R9 - software clears flags before re-enabling
// R10 - external events vector in 3-4 cycles
// R11 - pin edge chosen by option bit 6
// R12 - valid edge sets flag bit 1
// R13 - pin wakes sleep if enabled beforehand
// R14 - after wake vector only if enabled
// R15 - timer overflow sets flag bit 2
// R16 - port b 7:4 change sets flag 0
// R17 - only return pc saved on entry
// R18 - request is gated or of pairs
module vil_top (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_ext_interrupt_pin,
  input wire logic [3:0] i_port_b_a,
  input wire logic i_timer_ovf,
  input wire logic [7:0] i_periph_evt,
  input wire logic [12:0] i_pc,
  input wire logic i_return_from_irq_instr,
  input wire logic i_sleep,
  output logic o_irq_req,
  output logic o_vec_load,
  output logic [12:0] o_vec_pc,
  output logic o_push,
  output logic [12:0] o_push_pc,
  output logic o_pop,
  output logic o_asleep,
  output logic o_wake,
  output logic o_int
);
  // ***************************************************
  // declarations
  // ***************************************************
  typedef enum logic [1:0] {VIL_IDLE, VIL_WAIT} vil_st_t;
  vil_st_t st_ff; // vectoring sequencer
  logic [1:0] wcnt_ff; // instruction boundaries waited
  logic [1:0] q_ff; // quarter of instruction cycle
  logic q_tick; // last quarter, cycle boundary
  logic [7:0] ctrl_ff; // core interrupt control
  logic [7:0] pflag_ff; // peripheral flags
  logic [7:0] pen_ff; // peripheral enables
  logic [7:0] opt_ff; // option register
  logic [1:0] istat_ff; // sticky event status
  logic [1:0] imask_ff; // event mask
  logic ext_s1_ff, ext_s2_ff, ext_d_ff; // pin sync + delay
  logic [3:0] pb_s1_ff, pb_s2_ff, pb_d_ff; // port sync + delay
  logic ext_evt; // valid edge seen
  logic pb_evt; // port b change seen
  logic core_hit; // some core pair active
  logic per_hit; // some peripheral pair active
  logic take; // vector this cycle
  logic sleep_een_ff; // pin enable captured at sleep entry
  logic wake; // wake condition
  logic wr_ctrl;
  logic [7:0] nxt_pflag;

  // ***************************************************
  // instruction cycle divider
  // ***************************************************
  // four quarter-cycles per instruction cycle
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      q_ff <= 2'h0;
    end else begin
      q_ff <= q_ff + 2'h1;
    end
  end
  assign q_tick = (q_ff == vil_pkg::Q_LAST);

  // ***************************************************
  // pin synchronisers and event detectors
  // ***************************************************
  // second flop alone feeds the edge logic, first is isolated
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_d_ff <= 1'b0;
      pb_s1_ff <= 4'h0;
      pb_s2_ff <= 4'h0;
      pb_d_ff <= 4'h0;
    end else begin
      ext_s1_ff <= i_ext_interrupt_pin;
      ext_s2_ff <= ext_s1_ff;
      ext_d_ff <= ext_s2_ff;
      pb_s1_ff <= i_port_b_a;
      pb_s2_ff <= pb_s1_ff;
      pb_d_ff <= pb_s2_ff;
    end
  end
  // edge select: set = rising, clear = falling
  assign ext_evt = opt_ff[vil_pkg::B_EDGE] ?
                   (ext_s2_ff & ~ext_d_ff) : // R11
                   (~ext_s2_ff & ext_d_ff); // R11
  // any bit of the upper nibble moving counts
  assign pb_evt = |(pb_s2_ff ^ pb_d_ff); // R16
  // the reset value of the pins may cause one spurious
  // change flag just after release; software clears it

  // ***************************************************
  // register writes
  // ***************************************************
  assign wr_ctrl = i_wr && (i_addr == vil_pkg::OFS_CTRL);

  // core control: hardware set wins over software clear
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_ff <= vil_pkg::RST_CTRL; // R5
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= i_wdata;
      end
      // vector entry overrides a same-cycle write of the enable
      if (take) begin
        ctrl_ff[vil_pkg::B_GIE] <= 1'b0; // R6
      end else if (i_return_from_irq_instr) begin
        ctrl_ff[vil_pkg::B_GIE] <= 1'b1; // R7
      end
      // flags set whatever the enables say
      if (ext_evt) begin
        ctrl_ff[vil_pkg::B_EF] <= 1'b1; // R2 R12
      end
      if (i_timer_ovf) begin
        ctrl_ff[vil_pkg::B_TF] <= 1'b1; // R15
      end
      if (pb_evt) begin
        ctrl_ff[vil_pkg::B_PF] <= 1'b1; // R16
      end
    end
  end

  // peripheral flags, one per source bit
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pflag
      // event set beats a write of zero
      assign nxt_pflag[gi] = i_periph_evt[gi] | // R1 R2
        ((i_wr && i_addr == vil_pkg::OFS_PFLAG) ?
         i_wdata[gi] : pflag_ff[gi]);
    end
  endgenerate

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      pflag_ff <= vil_pkg::RST_ZERO;
    end else begin
      pflag_ff <= nxt_pflag; // R8
    end
  end

  // peripheral enables and option
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      pen_ff <= vil_pkg::RST_ZERO;
      opt_ff <= vil_pkg::RST_OPT;
      imask_ff <= 2'h0;
    end else if (i_wr) begin
      case (i_addr)
        vil_pkg::OFS_PEN: pen_ff <= i_wdata; // R8
        vil_pkg::OFS_OPT: opt_ff <= i_wdata; // R11
        vil_pkg::OFS_IMASK: imask_ff <= i_wdata[1:0];
        default: ;
      endcase
    end
  end

  // ***************************************************
  // request forming
  // ***************************************************
  assign core_hit =
    (ctrl_ff[vil_pkg::B_TF] & ctrl_ff[vil_pkg::B_TIE]) |
    (ctrl_ff[vil_pkg::B_EF] & ctrl_ff[vil_pkg::B_EIE]) |
    (ctrl_ff[vil_pkg::B_PF] & ctrl_ff[vil_pkg::B_PCE]); // R18
  assign per_hit = ctrl_ff[vil_pkg::B_PERIPHERAL_GROUP_ENABLE] &
                   (|(pflag_ff & pen_ff)); // R8 R18
  // a still-set flag keeps asking, so software must clear it
  assign o_irq_req = ctrl_ff[vil_pkg::B_GIE] &
                     (core_hit | per_hit); // R3 R4 R9

  // ***************************************************
  // vectoring sequencer
  // ***************************************************
  // no extra condition: a request waits only for the fixed
  // pipeline of boundaries, giving three or four cycles
  assign take = (st_ff == VIL_WAIT) && q_tick && o_irq_req &&
                (wcnt_ff == vil_pkg::WAIT_LAST); // R4 R10

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_ff <= VIL_IDLE;
      wcnt_ff <= 2'h0;
    end else begin
      case (st_ff)
        VIL_IDLE: begin
          // sleeping core fetches nothing, so it is not vectored
          if (q_tick && o_irq_req && !o_asleep) begin
            st_ff <= VIL_WAIT; // R10
            wcnt_ff <= 2'h1;
          end
        end
        VIL_WAIT: begin
          // request withdrawn by software: abandon
          if (!o_irq_req || take) begin
            st_ff <= VIL_IDLE;
            wcnt_ff <= 2'h0;
          end else if (q_tick) begin
            wcnt_ff <= wcnt_ff + 2'h1; // R10
          end
        end
        default: begin
          st_ff <= VIL_IDLE;
          wcnt_ff <= 2'h0;
        end
      endcase
    end
  end

  // vector outputs; only the return pc is handed to the stack
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_vec_load <= 1'b0;
      o_push <= 1'b0;
      o_vec_pc <= 13'h0000;
      o_push_pc <= 13'h0000;
      o_pop <= 1'b0;
    end else begin
      o_vec_load <= take; // R6
      o_push <= take; // R6 R17
      o_pop <= i_return_from_irq_instr; // R7
      if (take) begin
        o_vec_pc <= vil_pkg::VEC_PC; // R6
        o_push_pc <= i_pc; // R17
      end
    end
  end

  // ***************************************************
  // sleep and wake-up
  // ***************************************************
  // enable is sampled at entry; setting it later does not wake
  assign wake = o_asleep && sleep_een_ff &&
                ctrl_ff[vil_pkg::B_EF]; // R13

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_asleep <= 1'b0;
      sleep_een_ff <= 1'b0;
      o_wake <= 1'b0;
    end else begin
      o_wake <= wake; // R14
      if (wake) begin
        o_asleep <= 1'b0;
      end else if (i_sleep && !o_asleep) begin
        o_asleep <= 1'b1;
        sleep_een_ff <= ctrl_ff[vil_pkg::B_EIE]; // R13
      end
    end
  end
  // after wake the normal sequencer vectors only with the
  // global enable set; else execution simply continues

  // ***************************************************
  // event status, mask and interrupt line
  // ***************************************************
  // read clears, but a same-cycle event keeps its bit
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      istat_ff <= 2'h0;
    end else begin
      if (i_rd && i_addr == vil_pkg::OFS_ISTAT) begin
        istat_ff <= 2'h0;
      end
      if (take) begin
        istat_ff[vil_pkg::ST_VEC] <= 1'b1;
      end
      if (wake) begin
        istat_ff[vil_pkg::ST_WAKE] <= 1'b1;
      end
    end
  end
  assign o_int = |(istat_ff & imask_ff);

  // ***************************************************
  // register read port
  // ***************************************************
  // unmapped offsets read as zero
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        vil_pkg::OFS_CTRL: o_rdata <= ctrl_ff;
        vil_pkg::OFS_PFLAG: o_rdata <= pflag_ff;
        vil_pkg::OFS_PEN: o_rdata <= pen_ff;
        vil_pkg::OFS_OPT: o_rdata <= opt_ff;
        vil_pkg::OFS_ISTAT: o_rdata <= {6'h00, istat_ff};
        vil_pkg::OFS_IMASK: o_rdata <= {6'h00, imask_ff};
        vil_pkg::OFS_STATE: o_rdata <= {5'h00, o_asleep,
          st_ff == VIL_WAIT, o_irq_req};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ***************************************************
  // assertions
  // ***************************************************
  sequence s_req_boundary;
    q_tick && o_irq_req && !o_asleep && st_ff == VIL_IDLE;
  endsequence
  sequence s_vec_or_drop;
    ##[1:12] (o_vec_load || !o_irq_req);
  endsequence

  AST_GIE_RESET: assert property ( // R5
    @(posedge i_mclk) $rose(i_nrst) |-> !ctrl_ff[vil_pkg::B_GIE])
    else $error("global enable set after reset");
  AST_EXT_FLAG: assert property ( // R12
    @(posedge i_mclk) disable iff (!i_nrst)
    ext_evt |=> ctrl_ff[vil_pkg::B_EF])
    else $error("pin edge did not set flag");
  AST_TMR_FLAG: assert property ( // R15
    @(posedge i_mclk) disable iff (!i_nrst)
    i_timer_ovf |=> ctrl_ff[vil_pkg::B_TF])
    else $error("overflow did not set flag");
  AST_PB_FLAG: assert property ( // R16
    @(posedge i_mclk) disable iff (!i_nrst)
    pb_evt |=> ctrl_ff[vil_pkg::B_PF])
    else $error("port change did not set flag");
  AST_VEC_GIE: assert property ( // R6
    @(posedge i_mclk) disable iff (!i_nrst)
    $rose(o_vec_load) |-> !ctrl_ff[vil_pkg::B_GIE] && o_push
      && o_vec_pc == vil_pkg::VEC_PC)
    else $error("vector entry wrong");
  AST_RET_GIE: assert property ( // R7
    @(posedge i_mclk) disable iff (!i_nrst)
    i_return_from_irq_instr && !take |=>
      ctrl_ff[vil_pkg::B_GIE] && o_pop)
    else $error("return did not re-enable");
  AST_GIE_BLOCK: assert property ( // R3
    @(posedge i_mclk) disable iff (!i_nrst)
    !ctrl_ff[vil_pkg::B_GIE] |-> !o_irq_req && !take)
    else $error("request without global enable");
  AST_LATENCY: assert property ( // R10
    @(posedge i_mclk) disable iff (!i_nrst)
    s_req_boundary |-> s_vec_or_drop)
    else $error("vector latency exceeded");
  AST_WAKE: assert property ( // R13
    @(posedge i_mclk) disable iff (!i_nrst)
    o_asleep && !sleep_een_ff |=> !o_wake)
    else $error("wake without prior enable");
endmodule : vil_top

// ===== verif/vil_seq_model.sv
// Purpose: sequencer model: program counter, return stack, return pulse
// Assumes: one clock; the bench commands each return with a delay
// Notes: pc follows the bench value while no routine is active
`timescale 1ns/100ps
module vil_seq_model (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_vec_load,
  input wire logic [12:0] i_vec_pc,
  input wire logic i_push,
  input wire logic [12:0] i_push_pc,
  input wire logic i_pop,
  input wire logic [12:0] i_run_pc,
  input wire logic i_ret_go,
  input wire logic [3:0] i_ret_dly,
  output logic [12:0] o_pc,
  output logic o_ret
);
  logic [12:0] stk_ff [$]; // holds return pc only
  logic [4:0] cnt_ff; // cycles left before the return pulse
  // ***********************************************
  // pc and stack
  // ***********************************************
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pc <= i_run_pc;
      stk_ff.delete();
    end else begin
      if (i_push) stk_ff.push_back(i_push_pc);
      if (i_vec_load) o_pc <= i_vec_pc;
      else if (i_pop && stk_ff.size() > 0) o_pc <= stk_ff.pop_back();
      else if (stk_ff.size() == 0) o_pc <= i_run_pc;
    end
  end
  // ***********************************************
  // return instruction, prompt or slow
  // ***********************************************
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_ff <= 5'h00;
      o_ret <= 1'b0;
    end else begin
      o_ret <= (cnt_ff == 5'h01); // one-cycle pulse
      if (i_ret_go) cnt_ff <= {1'b0, i_ret_dly} + 5'h01;
      else if (cnt_ff != 5'h00) cnt_ff <= cnt_ff - 5'h01;
    end
  end
endmodule : vil_seq_model

// ===== verif/vil_top_tb.sv
// Purpose: self-checking bench for the interrupt logic
// Assumes: reads answer one cycle later; flags checked via reads
// Notes: a vector with no expectation queued counts as a mismatch
`timescale 1ns/100ps
module vil_top_tb;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic pin = 1'b0; // external pin level
  logic [3:0] pb = 4'h0; // port b upper nibble
  logic tovf = 1'b0;
  logic [7:0] pev = 8'h00;
  logic [7:0] pev_drv = 8'h00;
  logic slp = 1'b0;
  logic ret_go = 1'b0;
  logic [3:0] ret_dly = 4'h0;
  logic [12:0] run_pc = 13'h0000;
  logic [12:0] pc, push_pc, vec_pc;
  logic [7:0] rdata;
  logic ret, irq, vl, push, pop, asleep, wake, intr;
  logic [7:0] rdq [$]; // expected read data
  logic [12:0] vq [$]; // expected pushed pc
  logic rd_seen = 1'b0;
  int error_cnt = 0;
  int checks_done = 0;
  int seed;
  int lat;
  always #20 i_mclk = ~i_mclk;
  vil_top dut_u (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
    .i_ext_interrupt_pin(pin), .i_port_b_a(pb), .i_timer_ovf(tovf),
    .i_periph_evt(pev_drv), .i_pc(pc), .i_return_from_irq_instr(ret),
    .i_sleep(slp), .o_irq_req(irq), .o_vec_load(vl), .o_vec_pc(vec_pc),
    .o_push(push), .o_push_pc(push_pc), .o_pop(pop), .o_asleep(asleep),
    .o_wake(wake), .o_int(intr));
  vil_seq_model seq_u (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_vec_load(vl),
    .i_vec_pc(vec_pc), .i_push(push), .i_push_pc(push_pc), .i_pop(pop),
    .i_run_pc(run_pc), .i_ret_go(ret_go), .i_ret_dly(ret_dly), .o_pc(pc),
    .o_ret(ret));
  // ***********************************************
  // shared tasks
  // ***********************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic idle(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : idle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    rdq.push_back(e);
    @(posedge i_mclk);
    i_rd <= 1'b0;
  endtask : rd
  // note the vector, then wait for the monitor to consume it
  task automatic exp_vec(input logic [12:0] p);
    vq.push_back(p);
    lat = 0;
    while (vq.size() != 0 && lat < 40) begin
      @(negedge i_mclk);
      lat++;
    end
    check(16'(vq.size()), 16'h0000);
    vq.delete();
  endtask : exp_vec
  // a return from the routine after a random delay
  task automatic do_ret();
    @(posedge i_mclk);
    ret_go <= 1'b1;
    ret_dly <= 4'($random(seed));
    @(posedge i_mclk);
    ret_go <= 1'b0;
  endtask : do_ret
  // ***********************************************
  // monitor: oldest note against each result
  // ***********************************************
  always @(posedge i_mclk) begin
    if (rd_seen && rdq.size() > 0) check(rdata, rdq.pop_front());
    rd_seen = i_rd;
    if (vl) begin
      if (vq.size() == 0) check(16'h0001, 16'h0000);
      else check(push_pc, vq.pop_front());
      check(vec_pc, vil_pkg::VEC_PC);
      check(push, 1'b1);
    end
  end
  // ***********************************************
  // watchdog
  // ***********************************************
  initial begin
    #(40 * 5000);
    error_cnt++;
    conclude();
  end
  // ***********************************************
  // main sequence
  // ***********************************************
  initial begin
    seed = 9499;
    idle(5);
    i_nrst <= 1'b1;
    idle(2);
    rd(vil_pkg::OFS_CTRL, vil_pkg::RST_CTRL);
    rd(vil_pkg::OFS_OPT, vil_pkg::RST_OPT);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00);
    // every event with all enables off
    @(posedge i_mclk);
    tovf <= 1'b1;
    pev = 8'($random(seed)) | 8'h01;
    pev_drv <= pev;
    pb <= pb ^ (4'($random(seed)) | 4'h1);
    pin <= 1'b1;
    @(posedge i_mclk);
    tovf <= 1'b0;
    pev_drv <= 8'h00;
    idle(6);
    rd(vil_pkg::OFS_CTRL, 8'h07);
    rd(vil_pkg::OFS_PFLAG, pev);
    wr(vil_pkg::OFS_CTRL, 8'h3F);
    rd(vil_pkg::OFS_STATE, 8'h00);
    // falling edge selected
    wr(vil_pkg::OFS_CTRL, 8'h00);
    wr(vil_pkg::OFS_OPT, 8'hBF);
    pin <= 1'b0;
    idle(6);
    rd(vil_pkg::OFS_CTRL, 8'h02);
    wr(vil_pkg::OFS_CTRL, 8'h00);
    pin <= 1'b1;
    idle(6);
    rd(vil_pkg::OFS_CTRL, 8'h00);
    // peripheral vector, then recursion while flag stays set
    wr(vil_pkg::OFS_IMASK, 8'h03);
    run_pc <= 13'($random(seed));
    wr(vil_pkg::OFS_PEN, pev);
    wr(vil_pkg::OFS_CTRL, 8'hC0);
    // request must be up as soon as the enables land
    @(negedge i_mclk);
    check(irq, 1'b1);
    exp_vec(run_pc);
    rd(vil_pkg::OFS_CTRL, 8'h40);
    check(irq, 1'b0);
    check(intr, 1'b1);
    rd(vil_pkg::OFS_ISTAT, 8'h01);
    @(negedge i_mclk);
    check(intr, 1'b0);
    do_ret();
    exp_vec(run_pc);
    wr(vil_pkg::OFS_PFLAG, 8'h00);
    do_ret();
    idle(30);
    rd(vil_pkg::OFS_CTRL, 8'hC0);
    // pin vector latency
    wr(vil_pkg::OFS_CTRL, 8'h90);
    @(posedge i_mclk);
    pin <= 1'b0;
    exp_vec(run_pc);
    check(16'(lat >= 12 && lat <= 17), 16'h0001);
    // clear the flag first, or the return re-enters at once
    wr(vil_pkg::OFS_CTRL, 8'h10);
    do_ret();
    idle(20);
    // the return set the global enable; drop it for a quiet wake
    wr(vil_pkg::OFS_CTRL, 8'h10);
    rd(vil_pkg::OFS_ISTAT, 8'h01);
    // sleep, wake without vector
    pin <= 1'b1;
    idle(6);
    @(posedge i_mclk);
    slp <= 1'b1;
    @(posedge i_mclk);
    slp <= 1'b0;
    idle(2);
    rd(vil_pkg::OFS_STATE, 8'h04);
    check(asleep, 1'b1);
    pin <= 1'b0;
    lat = 0;
    while (wake !== 1'b1 && lat < 20) begin
      @(negedge i_mclk);
      lat++;
    end
    check(wake, 1'b1);
    check(asleep, 1'b0);
    idle(20);
    rd(vil_pkg::OFS_STATE, 8'h00);
    rd(vil_pkg::OFS_ISTAT, 8'h02);
    // sleep with the pin enable off stays asleep
    wr(vil_pkg::OFS_CTRL, 8'h00);
    pin <= 1'b1;
    idle(6);
    @(posedge i_mclk);
    slp <= 1'b1;
    @(posedge i_mclk);
    slp <= 1'b0;
    pin <= 1'b0;
    idle(20);
    rd(vil_pkg::OFS_STATE, 8'h04);
    rd(vil_pkg::OFS_CTRL, 8'h02);
    // let the last read answer be compared before reset wipes it
    idle(2);
    // second reset mid-run
    pb <= 4'h0;
    i_nrst <= 1'b0;
    idle(2);
    i_nrst <= 1'b1;
    idle(6);
    rd(vil_pkg::OFS_CTRL, 8'h00);
    rd(vil_pkg::OFS_STATE, 8'h00);
    // wake with global enable vectors
    wr(vil_pkg::OFS_CTRL, 8'h90);
    @(posedge i_mclk);
    slp <= 1'b1;
    @(posedge i_mclk);
    slp <= 1'b0;
    pin <= 1'b1;
    exp_vec(run_pc);
    idle(4);
    conclude();
  end
endmodule : vil_top_tb
